// File: verilog/mhpp_pkg.sv
package mhpp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int         DATA_W    = 8;
  localparam int         BUF_DEPTH = 12;
  localparam int         PTR_W     = 4;
  localparam logic [3:0] PTR_LAST  = 4'hb;
  localparam logic [3:0] PTR_FIRST = 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // Register select decode
  localparam logic [1:0] SEL_BUFFER  = 2'h0;
  localparam logic [1:0] SEL_STS_CMD = 2'h1;
  localparam logic [1:0] SEL_QLT_MOD = 2'h2;
  localparam logic [1:0] SEL_CONTROL = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CMD_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IDLE_BYTE  = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       selectLow;
    logic       readLow;
    logic       writeLow;
    logic [1:0] regSel;
    logic [7:0] busData;
  } mhpp_pins_t;

  localparam mhpp_pins_t PINS_IDLE = '{selectLow: 1'b1, readLow: 1'b1, writeLow: 1'b1,
                                       regSel: 2'h0, busData: 8'h00};

  typedef struct packed {
    logic [7:0] command;
    logic [7:0] mode;
    logic [7:0] control;
  } mhpp_ctrl_t;

  localparam mhpp_ctrl_t CTRL_IDLE = '{command: CMD_RESET, mode: MODE_RESET, control: CTRL_RESET};

  typedef struct packed {
    logic       we;
    logic [3:0] addr;
    logic [7:0] wdata;
  } mhpp_buf_req_t;

endpackage : mhpp_pkg

// File: verilog/mhpp_buffer.sv
module mhpp_buffer
  import mhpp_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // Host side access
  input  wire mhpp_buf_req_t hostReq,
  output logic [7:0]         hostRdata_r,
  // Modem side access
  input  wire mhpp_buf_req_t modemReq,
  output logic [7:0]         modemRdata_r
);

  logic [7:0] entry_r   [BUF_DEPTH];
  logic [7:0] entry_nxt [BUF_DEPTH];
  logic [7:0] hostRdata_nxt;
  logic [7:0] modemRdata_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Storage, host wins a same-entry collision since its cycle cannot be retried
  for (genvar i = 0; i < BUF_DEPTH; i++) begin : gEntry
    always_comb begin
      entry_nxt[i] = entry_r[i];
      if (modemReq.we && modemReq.addr == PTR_W'(i)) begin
        entry_nxt[i] = modemReq.wdata;
      end
      if (hostReq.we && hostReq.addr == PTR_W'(i)) begin
        entry_nxt[i] = hostReq.wdata;
      end
    end

    always_ff @(posedge core_clk) begin
      entry_r[i] <= rst ? IDLE_BYTE : entry_nxt[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered reads, out of range reads as zero
  always_comb begin
    hostRdata_nxt  = (hostReq.addr <= PTR_LAST) ? entry_r[hostReq.addr] : IDLE_BYTE;
    modemRdata_nxt = (modemReq.addr <= PTR_LAST) ? entry_r[modemReq.addr] : IDLE_BYTE;
  end

  always_ff @(posedge core_clk) begin
    hostRdata_r  <= rst ? IDLE_BYTE : hostRdata_nxt;
    modemRdata_r <= rst ? IDLE_BYTE : modemRdata_nxt;
  end

endmodule : mhpp_buffer

// File: verilog/mhpp_host_port.sv
module mhpp_host_port
  import mhpp_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // Host strobes and register select
  input  wire logic          selectLow,
  input  wire logic          readStrobeLow,
  input  wire logic          writeStrobeLow,
  input  wire logic          regSelectBit0,
  input  wire logic          regSelectBit1,
  // Host data bus, bit 7 is the msb lane and bit 0 the lsb lane
  input  wire logic [7:0]    busIn,
  output logic [7:0]         busOut,
  output logic               busOeLow,
  // Host interrupt request, open drain
  output logic               hostIrqLowOut,
  output logic               hostIrqLowOeLow,
  // Modem core: requests and readable state
  input  wire logic          irqPending,
  input  wire logic [7:0]    statusByte,
  input  wire logic [7:0]    qualityByte,
  // Modem core: host written registers
  output mhpp_ctrl_t         ctrlRegs,
  output logic               commandStrobe,
  // Modem core: buffer port
  input  wire mhpp_buf_req_t modemBufReq,
  output logic [7:0]         modemBufRdata
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  // Raw pins, synchroniser stages and the filtered pin view
  mhpp_pins_t    pinsRaw;
  mhpp_pins_t    sync1_r, sync2_r, sync3_r, filt_r;
  mhpp_pins_t    sync1_nxt, sync2_nxt, sync3_nxt, filt_nxt;
  mhpp_pins_t    agree;

  // Decoded access and the write in progress
  logic          selRead, selWrite;
  logic          readActive_r, readActive_nxt;
  logic          writeActive_r, writeActive_nxt;
  logic [1:0]    wrSel_r, wrSel_nxt;
  logic [7:0]    wrData_r, wrData_nxt;
  logic          writeCommit, readDone;

  // Host written registers and the buffer pointer
  mhpp_ctrl_t    ctrl_r, ctrl_nxt;
  logic          cmdStrobe_r, cmdStrobe_nxt;
  logic [3:0]    ptr_r, ptr_nxt;

  // Registered pin drives
  logic [7:0]    busOut_r, busOut_nxt;
  logic          busOeLow_r, busOeLow_nxt;
  logic          irqOeLow_r, irqOeLow_nxt;
  logic          irqOut_r;

  // Host side of the shared buffer
  mhpp_buf_req_t hostBufReq;
  logic [7:0]    hostBufRdata;

  // Gather the loose pins into one word so every bit sees the same filter
  assign pinsRaw = '{selectLow: selectLow, readLow: readStrobeLow, writeLow: writeStrobeLow,
                     regSel: {regSelectBit1, regSelectBit0}, busData: busIn};

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: three stages, a bit moves once stages two and three agree
  // Stage one may go metastable, so only stage two ever reads it; a bit that
  // toggles every cycle never agrees and the filtered view simply holds
  always_comb begin
    sync1_nxt = pinsRaw;
    sync2_nxt = sync1_r;
    sync3_nxt = sync2_r;
    agree     = ~(sync2_r ^ sync3_r);
    filt_nxt  = (agree & sync3_r) | (~agree & filt_r);
  end

  // All stages reset to idle pin levels so no false strobe follows reset
  always_ff @(posedge core_clk) begin
    sync1_r <= rst ? PINS_IDLE : sync1_nxt;
    sync2_r <= rst ? PINS_IDLE : sync2_nxt;
    sync3_r <= rst ? PINS_IDLE : sync3_nxt;
    filt_r  <= rst ? PINS_IDLE : filt_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe decode, a strobe without chip select is no access at all
  always_comb begin
    selRead  = ~filt_r.selectLow & ~filt_r.readLow;
    selWrite = ~filt_r.selectLow & ~filt_r.writeLow;
    readActive_nxt  = selRead;
    writeActive_nxt = selWrite;
    // A write ends when the strobe or the select goes away, whichever comes first
    writeCommit = writeActive_r & ~selWrite;
    // A read ends the same way; the pointer only steps once the host lets go
    readDone    = readActive_r & ~selRead;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write capture: address and data are recaptured every cycle while the write is live, so the
  // byte committed is the last one seen before the strobe rose
  always_comb begin
    // Hold the captured values once the write has gone
    wrSel_nxt  = wrSel_r;
    wrData_nxt = wrData_r;
    if (selWrite) begin
      wrSel_nxt  = filt_r.regSel;
      wrData_nxt = filt_r.busData;
    end
  end

  // Activity flags and capture; reset leaves no write pending
  always_ff @(posedge core_clk) begin
    readActive_r  <= rst ? 1'b0 : readActive_nxt;
    writeActive_r <= rst ? 1'b0 : writeActive_nxt;
    wrSel_r       <= rst ? SEL_BUFFER : wrSel_nxt;
    wrData_r      <= rst ? IDLE_BYTE : wrData_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes and buffer pointer
  // The pointer steps after every buffer byte in either direction and
  // wraps after the twelfth; a command write rewinds it, which lets the
  // host load a block and then start the transfer without counting bytes
  always_comb begin
    // Defaults: nothing changes and the buffer is not written
    ctrl_nxt      = ctrl_r;
    cmdStrobe_nxt = 1'b0;
    ptr_nxt       = ptr_r;
    // The address comes from the pointer and the data from the capture register, never from the live pins
    hostBufReq    = '{we: 1'b0, addr: ptr_r, wdata: wrData_r};
    if (writeCommit) begin
      case (wrSel_r)
        SEL_BUFFER: begin
          hostBufReq.we = 1'b1;
          // Step after the byte lands, wrapping after the last entry
          ptr_nxt = (ptr_r == PTR_LAST) ? PTR_FIRST : ptr_r + 4'h1;
        end
        SEL_STS_CMD: begin
          ctrl_nxt.command = wrData_r;
          cmdStrobe_nxt    = 1'b1;
          ptr_nxt          = PTR_FIRST;
        end
        SEL_QLT_MOD: begin
          ctrl_nxt.mode = wrData_r;
        end
        SEL_CONTROL: begin
          ctrl_nxt.control = wrData_r;
        end
        default: begin
          ctrl_nxt = ctrl_r;
        end
      endcase
    end else if (readDone && filt_r.regSel == SEL_BUFFER) begin
      ptr_nxt = (ptr_r == PTR_LAST) ? PTR_FIRST : ptr_r + 4'h1;
    end
  end

  // Registering the strobe gives the core one clean pulse per command
  always_ff @(posedge core_clk) begin
    ctrl_r      <= rst ? CTRL_IDLE : ctrl_nxt;
    cmdStrobe_r <= rst ? 1'b0 : cmdStrobe_nxt;
    ptr_r       <= rst ? PTR_FIRST : ptr_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Data buffer shared with the modem core
  // The modem reaches the same entries through its own port; a host write wins a clash
  mhpp_buffer uBuffer (
    .core_clk     (core_clk),
    .rst          (rst),
    .hostReq      (hostBufReq),
    .hostRdata_r  (hostBufRdata),
    .modemReq     (modemBufReq),
    .modemRdata_r (modemBufRdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read path: the byte is muxed every cycle so a changing status is seen
  // live, at the cost of the host needing to hold the strobe a few cycles
  always_comb begin
    case (filt_r.regSel)
      SEL_BUFFER:  busOut_nxt = hostBufRdata;
      SEL_STS_CMD: busOut_nxt = statusByte;
      SEL_QLT_MOD: busOut_nxt = qualityByte;
      default:     busOut_nxt = IDLE_BYTE;
    endcase
    // Outside a selected read the byte is forced idle so nothing stale lingers
    if (!selRead) begin
      busOut_nxt = IDLE_BYTE;
    end
    // Enable low means driving; it trails the filtered read by one edge
    busOeLow_nxt = ~selRead;
  end

  // Bus drive is released through reset so the host bus is never fought
  always_ff @(posedge core_clk) begin
    busOut_r   <= rst ? IDLE_BYTE : busOut_nxt;
    busOeLow_r <= rst ? 1'b1 : busOeLow_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pin: only ever pulls low, the release lets other sources share it
  always_comb begin
    irqOeLow_nxt = ~irqPending;
  end

  // Registered so the shared line cannot glitch while the pending level settles;
  // the drive value is tied low and only the enable moves, so it never drives high
  always_ff @(posedge core_clk) begin
    irqOeLow_r <= rst ? 1'b1 : irqOeLow_nxt;
    irqOut_r   <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Every pin and core output is a flop, so the host never sees a decode glitch
  assign busOut          = busOut_r;
  assign busOeLow        = busOeLow_r;
  assign hostIrqLowOut   = irqOut_r;
  assign hostIrqLowOeLow = irqOeLow_r;
  assign ctrlRegs        = ctrl_r;
  assign commandStrobe   = cmdStrobe_r;

endmodule : mhpp_host_port

// File: tb/mhpp_host_port_props.sv
module mhpp_host_port_props
  import mhpp_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Host pins
  input wire logic       selectLow,
  input wire logic       readStrobeLow,
  // Port outputs and modem request
  input wire logic       busOeLow,
  input wire logic       hostIrqLowOeLow,
  input wire logic       irqPending,
  input wire mhpp_ctrl_t ctrlRegs,
  input wire logic       commandStrobe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] rdHist_r;
  logic [7:0] rdHist_nxt;
  ////////////////////////////////////////////////////////////
  // Recent selected reads; the filter delays any answer by a few cycles
  always_comb rdHist_nxt = {rdHist_r[6:0], !selectLow && !readStrobeLow};
  always_ff @(posedge core_clk) rdHist_r <= rdHist_nxt;
  // Pin held long enough for the filter to pass it
  sequence s_rdHeld;
    (!selectLow && !readStrobeLow)[*6];
  endsequence
  sequence s_deselected;
    selectLow[*8];
  endsequence
  property p_irqPull;
    irqPending |=> !hostIrqLowOeLow;
  endproperty
  a_irqPull: assert property (p_irqPull) else $error("irq not pulled");
  property p_irqRelease;
    !irqPending |=> hostIrqLowOeLow;
  endproperty
  a_irqRelease: assert property (p_irqRelease) else $error("irq not released");
  property p_busAnswer;
    s_rdHeld |-> !busOeLow;
  endproperty
  a_busAnswer: assert property (p_busAnswer) else $error("read not answered");
  property p_busRelease;
    readStrobeLow[*6] |-> busOeLow;
  endproperty
  a_busRelease: assert property (p_busRelease) else $error("bus held");
  property p_busCause;
    $fell(busOeLow) |-> rdHist_r != 8'h00;
  endproperty
  a_busCause: assert property (p_busCause) else $error("bus driven unasked");
  property p_deselect;
    s_deselected |-> busOeLow && !commandStrobe && $stable(ctrlRegs);
  endproperty
  a_deselect: assert property (p_deselect) else $error("acted while deselected");
  property p_cmdOnce;
    commandStrobe |=> (!commandStrobe)[*4];
  endproperty
  a_cmdOnce: assert property (p_cmdOnce) else $error("command committed twice");
  property p_cmdWithStrobe;
    $changed(ctrlRegs.command) |-> commandStrobe;
  endproperty
  a_cmdWithStrobe: assert property (p_cmdWithStrobe) else $error("silent command");
endmodule : mhpp_host_port_props

bind mhpp_host_port mhpp_host_port_props u_props (.*);

// File: tb/mhpp_host_model.sv
module mhpp_host_model
  import mhpp_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Pins toward the port
  output mhpp_pins_t      pins,
  output logic [7:0]      hostBus,
  input  wire logic [7:0] busSeen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       drive  = 1'b0;
  logic [7:0] wander = 8'h5a;
  initial pins = PINS_IDLE;
  // A released bus keeps changing, so a stale byte never passes for an answer
  always @(posedge core_clk) wander <= ~wander;
  assign hostBus = drive ? pins.busData : wander;
  ////////////////////////////////////////////////////////////
  // One bus cycle; select may stay high to show the port ignores it
  task automatic xfer(input bit wr, input bit cs, input logic [1:0] sel, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge core_clk);
    pins.selectLow <= !cs;
    pins.regSel    <= sel;
    pins.busData   <= d;
    drive          <= wr;
    pins.readLow   <= wr;
    pins.writeLow  <= !wr;
    repeat (8) @(posedge core_clk);
    q = busSeen;
    pins.readLow  <= 1'b1;
    pins.writeLow <= 1'b1;
    // Address and data stay put well past the end of the strobe
    repeat (6) @(posedge core_clk);
    pins.selectLow <= 1'b1;
    drive          <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : xfer
endmodule : mhpp_host_model

// File: tb/tb_modem_host_parallel_port.sv
module tb_modem_host_parallel_port
  import mhpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          core_clk = 1'b0, rst = 1'b1, irqPending = 1'b0;
  logic          busOeLow, irqOe, irqOut, cmdStb, irqLine, cs;
  logic [7:0]    statusByte = 8'h00, qualityByte = 8'h00;
  logic [7:0]    busOut, busIn, hostBus, modemRd, q, d;
  logic [7:0]    exp [12];
  logic [7:0]    er [4];
  logic [1:0]    sel;
  mhpp_buf_req_t modemReq = '0;
  mhpp_ctrl_t    ctrl;
  mhpp_pins_t    pins;
  int            num_errors = 0, checked = 0, strobes = 0, n;
  always #5 core_clk = ~core_clk;
  // Wire levels: the port wins while enabled, the interrupt line has a pull-up
  assign busIn   = busOeLow ? hostBus : busOut;
  assign irqLine = irqOe ? 1'b1 : irqOut;
  always @(posedge core_clk) if (cmdStb === 1'b1) strobes++;
  mhpp_host_model HOST (.core_clk(core_clk), .pins(pins), .hostBus(hostBus), .busSeen(busIn));
  mhpp_host_port DUT (.core_clk(core_clk), .rst(rst), .selectLow(pins.selectLow), .readStrobeLow(pins.readLow),
    .writeStrobeLow(pins.writeLow), .regSelectBit0(pins.regSel[0]), .regSelectBit1(pins.regSel[1]), .busIn(busIn),
    .busOut(busOut), .busOeLow(busOeLow), .hostIrqLowOut(irqOut), .hostIrqLowOeLow(irqOe), .irqPending(irqPending),
    .statusByte(statusByte), .qualityByte(qualityByte), .ctrlRegs(ctrl), .commandStrobe(cmdStb),
    .modemBufReq(modemReq), .modemBufRdata(modemRd));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  function automatic logic [7:0] expRead(input logic [1:0] s);
    return s == SEL_STS_CMD ? statusByte : s == SEL_QLT_MOD ? qualityByte : IDLE_BYTE;
  endfunction : expRead
  // Modem side access; read data is registered one edge after the address
  task automatic modem(input logic we, input logic [3:0] a, input logic [7:0] wd);
    @(posedge core_clk);
    modemReq <= '{we: we, addr: a, wdata: wd};
    repeat (2) @(posedge core_clk);
    modemReq.we <= 1'b0;
  endtask : modem
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    final_report();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(90805));
    er = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    // Register traffic; the last command write is sent deselected
    for (int i = 0; i < 7; i++) begin
      d = 8'($urandom);
      sel = 2'(i % 3 + 1);
      cs = (i != 6);
      n = strobes;
      statusByte <= 8'($urandom);
      qualityByte <= 8'($urandom);
      irqPending <= 1'($urandom);
      HOST.xfer(1'b1, cs, sel, d, q);
      if (cs) er[sel] = d;
      check("command", ctrl.command, er[1]);
      check("mode", ctrl.mode, er[2]);
      check("control", ctrl.control, er[3]);
      check("strobes", 8'(strobes - n), 8'(cs && sel == SEL_STS_CMD));
      check("irq", irqLine, !irqPending);
      HOST.xfer(1'b0, cs, sel, 8'h00, q);
      if (cs) check("regRead", q, expRead(sel));
    end
    // Host loads a block, then issues the command that sends it
    for (int i = 0; i < 12; i++) begin
      exp[i] = 8'($urandom);
      HOST.xfer(1'b1, 1'b1, SEL_BUFFER, exp[i], q);
    end
    HOST.xfer(1'b1, 1'b1, SEL_STS_CMD, 8'h01, q);
    for (int i = 0; i < 13; i++) begin
      modem(1'b0, 4'(i), 8'h00);
      check("modemRd", modemRd, i < 12 ? exp[i % 12] : IDLE_BYTE);
    end
    // Modem fills the buffer; the host drains it and wraps to the first byte
    for (int i = 0; i < 12; i++) begin
      exp[i] = 8'($urandom);
      modem(1'b1, 4'(i), exp[i]);
    end
    for (int i = 0; i < 13; i++) begin
      HOST.xfer(1'b0, 1'b1, SEL_BUFFER, 8'h00, q);
      check("hostRd", q, exp[i % 12]);
    end
    final_report();
  end
endmodule : tb_modem_host_parallel_port
